// ==== bench/msl_fabric_model.sv ====
// Fabric model that presents operands and pulses one stage clock source.
`timescale 1ns/1ns
module msl_fabric_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bench request
   input wire logic req,
   input wire logic [1:0] src,
   input wire msl_pkg::msl_in_s cmd,
   output logic done,
   // Slice side
   output msl_pkg::msl_in_s drv,
   output logic [3:0] clk_src
);
   logic busy;
   initial drv = '0;
   always @(posedge aclk) begin
      done <= aresetn && busy;
      clk_src <= (aresetn && req && !busy) ? 4'h1 << src : 4'h0;
      if (!aresetn) begin
         busy <= 1'b0;
      end else if (req && !busy) begin
         drv <= cmd;
         busy <= 1'b1;
      end else if (busy) begin
         busy <= 1'b0;
      end
   end
endmodule : msl_fabric_model

// ==== bench/msl_slice_properties.sv ====
// Checker of output relations of the multiply-accumulate slice.
`timescale 1ns/1ns
module msl_slice_properties (
   // Clock and resets
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] stage_rst,
   // Results
   input wire logic [msl_pkg::ACC_W-1:0] result,
   input wire logic [msl_pkg::ACC_W-1:0] cascade_out,
   input wire msl_pkg::msl_flags_s flags,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Interrupt
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_range_combined: assert property (
      flags.accum_range_error_flag == (flags.overflow | flags.underflow))
      else $error("combined range flag differs from its parts");
   a_range_exclusive: assert property (
      !(flags.overflow && flags.underflow))
      else $error("overflow and underflow set together");
   a_zero_tracks: assert property (
      $changed(result) && !$past(|stage_rst)
      |-> flags.result_zero_flag == (result == '0))
      else $error("zero flag does not follow result");
   a_zero_masked: assert property (
      flags.result_zero_flag |-> flags.masked_zero_flag)
      else $error("zero result without masked zero flag");
   a_cascade_mirror: assert property (
      cascade_out == result)
      else $error("cascade output differs from result");
   a_over_registered: assert property (
      $rose(flags.overflow) |-> $changed(result))
      else $error("overflow rose without a result update");
   a_reset_clears: assert property (
      $rose(aresetn) |-> result == '0 && flags == '0 && !s_axi_bvalid)
      else $error("outputs not cleared by reset");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read data missing");
   a_read_refused: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");

   c_overflow: cover property ($rose(flags.overflow));
   c_irq: cover property ($rose(irq));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : msl_slice_properties

bind msl_slice msl_slice_properties msl_slice_properties_i (.aclk,
   .aresetn, .stage_rst, .result, .cascade_out, .flags, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .irq);

// ==== bench/tb.sv ====
// Self-checking testbench of the multiply-accumulate slice.
`timescale 1ns/1ns
module tb;
   logic aclk, aresetn, req, done, irq;
   logic [1:0] src, stage_ce, stage_rst, osel, s_axi_bresp, s_axi_rresp;
   msl_pkg::msl_in_s cmd, drv;
   msl_pkg::msl_flags_s flags;
   logic [3:0] clk_src, s_axi_wstrb;
   logic [31:0] casc, result, cascade_out, s_axi_wdata, s_axi_rdata;
   logic [23:0] rounded_result, rd_v;
   logic [7:0] s_axi_awaddr, s_axi_araddr, fl_v, stat_v;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, rnd_on, pon;
   logic [31:0] r_v, mask_v, pat_v, irqm;
   longint acc, hp;
   int mismatches, n_compared;
   logic [7:0] rst_ofs [5] = '{msl_pkg::CTRL_OFS, msl_pkg::STAGE_OFS,
      msl_pkg::MASK_OFS, msl_pkg::PATTERN_OFS, msl_pkg::IRQ_MASK_OFS};

   msl_fabric_model msl_fabric_model_i (.aclk, .aresetn, .req, .src, .cmd,
      .done, .drv, .clk_src);
   msl_slice msl_slice_i (.aclk, .aresetn, .operand_a(drv.a),
      .operand_b(drv.b), .op_sel(drv.op), .load_en(drv.load),
      .load_value(drv.load_value), .cascade_in(casc),
      .clock_source_0(clk_src[0]), .clock_source_1(clk_src[1]),
      .clock_source_2(clk_src[2]), .clock_source_3(clk_src[3]), .stage_ce,
      .stage_rst, .result, .rounded_result, .cascade_out, .flags,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .irq);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic lim(input int n);
      if (n >= 50) begin
         mismatches++;
         $display("[ERR] %0t wait too long", $time);
         final_report();
      end
   endtask : lim

   task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      lim(n);
      check(s_axi_bresp, er);
   endtask : wr

   task automatic rchk(input logic [7:0] ad, input logic [31:0] ed,
                       input logic [1:0] er);
      int n;
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      lim(n);
      check(s_axi_rdata, ed);
      check(s_axi_rresp, er);
   endtask : rchk

   function automatic logic [7:0] xflags(logic [31:0] r, logic ov,
                                         logic un);
      logic [31:0] k;
      k = ~mask_v;
      return {ov | un, un, ov, ((r ^ ~pat_v) & k) == 0,
              ((r ^ pat_v) & k) == 0, (r & k) == k, (r & k) == 0, r == 0};
   endfunction : xflags

   task automatic mac(input logic [1:0] s, input msl_pkg::msl_op_e op,
                      input int a, input int b, input logic ld,
                      input logic [31:0] lv);
      msl_pkg::msl_in_s c;
      longint base;
      longint sum, p;
      int n;
      c.load = ld;
      c.op = op;
      c.load_value = lv;
      c.a = a[11:0];
      c.b = b[11:0];
      base = ld ? longint'(signed'(lv)) : acc;
      if (!ld && op == msl_pkg::OP_CASC) base = longint'(signed'(casc));
      p = pon ? hp : a * b;
      sum = op == msl_pkg::OP_SUB ? base - p :
            op == msl_pkg::OP_PASS ? p : base + p;
      cmd <= c;
      src <= s;
      req <= 1'b1;
      @(posedge aclk);
      req <= 1'b0;
      for (n = 0; n < 50 && done !== 1'b1; n++) @(posedge aclk);
      lim(n);
      if (s == osel && stage_ce[0]) begin
         r_v = sum[31:0];
         acc = longint'(signed'(r_v));
         fl_v = xflags(r_v, sum > 64'sd2147483647, sum < -64'sd2147483648);
         stat_v |= fl_v;
         rd_v = r_v[31:8];
         if (rnd_on && (r_v[7:0] > 8'h80 || r_v[8:0] == 9'h180))
            rd_v = rd_v + 24'h1;
      end
      check(result, r_v);
      check(cascade_out, r_v);
      check(flags, fl_v);
      check(rounded_result, rd_v);
      check(irq, |(stat_v & irqm[7:0]));
   endtask : mac

   initial begin
      {aresetn, req, src, cmd, stage_rst, osel, rnd_on, pon, acc} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, r_v, fl_v, stat_v} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, rd_v} = '0;
      {mismatches, n_compared} = '0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb, stage_ce} = 8'hFD;
      casc = 32'h0000_03E8;
      mask_v = 32'hFFFF_FF00;
      pat_v = 32'h0000_0058;
      irqm = 32'h0000_0001;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rst_ofs[i]) rchk(rst_ofs[i], 32'h0, msl_pkg::RESP_OKAY);
      rchk(8'h40, 32'h0, msl_pkg::RESP_SLVERR);
      wr(msl_pkg::RESULT_OFS, 32'h1, msl_pkg::RESP_SLVERR);
      wr(msl_pkg::MASK_OFS, mask_v, msl_pkg::RESP_OKAY);
      wr(msl_pkg::PATTERN_OFS, pat_v, msl_pkg::RESP_OKAY);
      wr(msl_pkg::IRQ_MASK_OFS, irqm, msl_pkg::RESP_OKAY);
      rchk(msl_pkg::MASK_OFS, mask_v, msl_pkg::RESP_OKAY);
      mac(0, msl_pkg::OP_ACC, 3, -4, 1'b1, 32'h0000_0064);
      mac(0, msl_pkg::OP_ACC, 5, 6, 1'b0, 32'h0);
      mac(0, msl_pkg::OP_SUB, 2, 3, 1'b0, 32'h0);
      mac(0, msl_pkg::OP_CASC, 1, 1, 1'b0, 32'h0);
      mac(0, msl_pkg::OP_PASS, -89, 1, 1'b0, 32'h0);
      mac(0, msl_pkg::OP_PASS, 15, 17, 1'b0, 32'h0);
      mac(0, msl_pkg::OP_ACC, 1, 1, 1'b1, 32'h7FFF_FFFF);
      mac(0, msl_pkg::OP_SUB, 1, 1, 1'b1, 32'h8000_0000);
      mac(0, msl_pkg::OP_PASS, 0, 5, 1'b0, 32'h0);
      rchk(msl_pkg::STATUS_OFS, {24'h0, stat_v}, msl_pkg::RESP_OKAY);
      stat_v = 8'h00;
      check(irq, 1'b0);
      irqm = 32'h0;
      wr(msl_pkg::IRQ_MASK_OFS, irqm, msl_pkg::RESP_OKAY);
      mac(0, msl_pkg::OP_PASS, 0, 7, 1'b0, 32'h0);
      rchk(msl_pkg::STATUS_OFS, {24'h0, stat_v}, msl_pkg::RESP_OKAY);
      stat_v = 8'h00;
      osel = 2'd2;
      wr(msl_pkg::STAGE_OFS, 32'h0000_8000, msl_pkg::RESP_OKAY);
      mac(0, msl_pkg::OP_PASS, 9, 9, 1'b0, 32'h0);
      mac(2, msl_pkg::OP_ACC, 9, 9, 1'b0, 32'h0);
      stage_ce <= 2'b00;
      mac(2, msl_pkg::OP_ACC, 4, 4, 1'b0, 32'h0);
      stage_ce <= 2'b01;
      rnd_on = 1'b1;
      wr(msl_pkg::CTRL_OFS, 32'h0000_0001, msl_pkg::RESP_OKAY);
      mac(2, msl_pkg::OP_PASS, 24, 16, 1'b0, 32'h0);
      mac(2, msl_pkg::OP_PASS, 40, 16, 1'b0, 32'h0);
      wr(msl_pkg::STAGE_OFS, 32'h0001_8028, msl_pkg::RESP_OKAY);
      pon = 1'b1;
      hp = 9 * 9;
      mac(2, msl_pkg::OP_PASS, 5, 3, 1'b0, 32'h0);
      stage_rst <= 2'b01;
      repeat (2) @(posedge aclk);
      check(result, 32'h0);
      final_report();
   end
endmodule : tb

// ==== rtl/msl_flags.sv ====
// Compare logic for the result flags.
`timescale 1ns/1ns
module msl_flags (
   // Candidate result and compare settings
   input wire logic [msl_pkg::ACC_W-1:0] value,
   input wire logic [msl_pkg::ACC_W-1:0] mask,
   input wire logic [msl_pkg::ACC_W-1:0] pattern,
   input wire logic over,
   input wire logic under,
   // Flags
   output msl_pkg::msl_flags_s flags
);
   // A mask bit of one excludes that result bit from the compares.
   logic [msl_pkg::ACC_W-1:0] keep;

   assign keep = ~mask;
   assign flags.result_zero_flag = (value == '0);
   assign flags.masked_zero_flag = ((value & keep) == '0);
   assign flags.masked_ones_flag = ((value | mask) == '1);
   assign flags.pattern_match_flag = (((value ^ pattern) & keep) == '0);
   assign flags.inverse_pattern_match_flag =
      (((value ^ ~pattern) & keep) == '0);
   assign flags.overflow = over;
   assign flags.underflow = under;
   assign flags.accum_range_error_flag = over | under;
endmodule : msl_flags

// ==== rtl/msl_pkg.sv ====
// Shared constants, types and helpers for the multiply-accumulate slice.
package msl_pkg;

   // Datapath widths.
   localparam int A_W = 12;
   localparam int P_W = 24;
   localparam int ACC_W = 32;
   localparam int RND_W = 8;
   localparam int RND_OUT_W = 24;
   localparam int FLAG_W = 8;
   localparam int CFG_W = 6;

   // Register bus.
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STAGE_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] MASK_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] PATTERN_OFS = 8'h0C;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h14;
   localparam logic [ADDR_W-1:0] RESULT_OFS = 8'h18;
   localparam logic [ADDR_W-1:0] FLAGS_OFS = 8'h1C;
   localparam logic [ADDR_W-1:0] ROUNDED_OFS = 8'h20;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Field positions and reset values.
   localparam int CTRL_ROUND_BIT = 0;
   localparam int IN_CFG_LSB = 0;
   localparam int PIPE_CFG_LSB = 6;
   localparam int OUT_CFG_LSB = 12;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] STAGE_RST = 32'h0000_0000;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   localparam logic [31:0] PATTERN_RST = 32'h0000_0000;
   localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      OP_ACC = 2'b00,
      OP_SUB = 2'b01,
      OP_CASC = 2'b10,
      OP_PASS = 2'b11
   } msl_op_e;

   typedef struct packed {
      logic en;
      logic async_rst;
      logic [1:0] clk_sel;
      logic ce_sel;
      logic rst_sel;
   } msl_stage_cfg_s;

   typedef struct packed {
      logic load;
      msl_op_e op;
      logic [ACC_W-1:0] load_value;
      logic signed [A_W-1:0] a;
      logic signed [A_W-1:0] b;
   } msl_in_s;

   typedef struct packed {
      logic load;
      msl_op_e op;
      logic [ACC_W-1:0] load_value;
      logic signed [P_W-1:0] product;
   } msl_pipe_s;

   typedef struct packed {
      logic accum_range_error_flag;
      logic underflow;
      logic overflow;
      logic inverse_pattern_match_flag;
      logic pattern_match_flag;
      logic masked_ones_flag;
      logic masked_zero_flag;
      logic result_zero_flag;
   } msl_flags_s;

   function automatic logic stage_go(msl_stage_cfg_s c, logic [3:0] rise,
                                     logic [1:0] ce);
      return rise[c.clk_sel] & ce[c.ce_sel];
   endfunction : stage_go

   function automatic logic stage_clr(msl_stage_cfg_s c, logic [3:0] rise,
                                      logic [1:0] rst);
      return rst[c.rst_sel] & (c.async_rst | rise[c.clk_sel]);
   endfunction : stage_clr

   function automatic logic [31:0] apply_strb(logic [31:0] old,
                                              logic [31:0] data,
                                              logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return r;
   endfunction : apply_strb

endpackage : msl_pkg

// ==== rtl/msl_slice.sv ====
// Multiply-accumulate slice with flags, stage control and register bus.
//
// Notes on behaviour
// - Multiply both operands and add product to accumulator; show the sum.
// - Input and pipeline register stages are each included or bypassed.
// - The output register always holds the accumulator; no bypass.
// - The fabric may load the accumulator with a start value at any time.
// - Overflow indication is taken from a register.
// - Flag an all-zero result, and a zero result in unmasked bits.
// - Flag a result whose unmasked bits are all one.
// - Flag a result equal to the pattern in unmasked bits.
// - Flag a result equal to the inverted pattern in unmasked bits.
// - Separate overflow and underflow flags plus a combined flag.
// - Each stage picks one of four clock sources.
// - Each stage picks its own clock enable and reset.
// - All registers reset synchronously; an immediate reset is selectable.
// - The operation may be chosen by the fabric on every cycle.
// - A cascade path links neighbouring slices for wider arithmetic.
// - Convergent round-half-to-even rounding is selectable.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
module msl_slice (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Fabric operands and operation
   input wire logic signed [msl_pkg::A_W-1:0] operand_a,
   input wire logic signed [msl_pkg::A_W-1:0] operand_b,
   input wire msl_pkg::msl_op_e op_sel,
   input wire logic load_en,
   input wire logic [msl_pkg::ACC_W-1:0] load_value,
   input wire logic [msl_pkg::ACC_W-1:0] cascade_in,
   // Stage clock sources, enables and resets
   input wire logic clock_source_0,
   input wire logic clock_source_1,
   input wire logic clock_source_2,
   input wire logic clock_source_3,
   input wire logic [1:0] stage_ce,
   input wire logic [1:0] stage_rst,
   // Results
   output logic [msl_pkg::ACC_W-1:0] result,
   output logic [msl_pkg::RND_OUT_W-1:0] rounded_result,
   output logic [msl_pkg::ACC_W-1:0] cascade_out,
   output msl_pkg::msl_flags_s flags,
   // AXI4-Lite write address
   input wire logic [msl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [msl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt
   output logic irq
);
   // Configuration and status registers.
   logic [31:0] ctrl;
   logic [31:0] stage_reg;
   logic [31:0] mask;
   logic [31:0] pattern;
   logic [31:0] irq_mask;
   logic [msl_pkg::FLAG_W-1:0] status;

   // Stage control.
   logic [3:0] src_now;
   logic [3:0] src_prev;
   logic [3:0] clk_rise;
   msl_pkg::msl_stage_cfg_s in_cfg;
   msl_pkg::msl_stage_cfg_s pipe_cfg;
   msl_pkg::msl_stage_cfg_s out_cfg;
   logic out_go;
   logic out_clr;
   logic out_fire;

   // Datapath.
   msl_pkg::msl_in_s in_d;
   msl_pkg::msl_in_s in_q;
   msl_pkg::msl_pipe_s pipe_d;
   msl_pkg::msl_pipe_s pipe_q;
   logic [msl_pkg::ACC_W-1:0] acc;
   logic signed [msl_pkg::ACC_W:0] base;
   logic signed [msl_pkg::ACC_W:0] prod_ext;
   logic signed [msl_pkg::ACC_W:0] sum;
   logic [msl_pkg::ACC_W-1:0] next_acc;
   logic next_over;
   logic next_under;
   logic [msl_pkg::RND_OUT_W-1:0] next_round;
   logic round_up;
   msl_pkg::msl_flags_s next_flags;

   // Bus slave state.
   logic aw_hold;
   logic [msl_pkg::ADDR_W-1:0] aw_addr;
   logic w_hold;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic wr_ok;
   logic ar_take;
   logic [31:0] rd_data;
   logic rd_ok;

   // Clock sources are sampled and their rising edges become stage ticks.
   assign src_now = {clock_source_3, clock_source_2,
                     clock_source_1, clock_source_0};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_prev <= 4'h0;
      end else begin
         src_prev <= src_now;
      end
   end

   assign clk_rise = src_now & ~src_prev;
   assign in_cfg = stage_reg[msl_pkg::IN_CFG_LSB +: msl_pkg::CFG_W];
   assign pipe_cfg = stage_reg[msl_pkg::PIPE_CFG_LSB +: msl_pkg::CFG_W];
   assign out_cfg = stage_reg[msl_pkg::OUT_CFG_LSB +: msl_pkg::CFG_W];
   assign out_go = msl_pkg::stage_go(out_cfg, clk_rise, stage_ce);
   assign out_clr = msl_pkg::stage_clr(out_cfg, clk_rise, stage_rst);
   assign out_fire = out_go & ~out_clr;

   // Operation and operands travel together so a per-cycle choice stays
   // aligned with its own data through the optional stages.
   always_comb begin
      in_d.load = load_en;
      in_d.op = op_sel;
      in_d.load_value = load_value;
      in_d.a = operand_a;
      in_d.b = operand_b;
   end

   msl_stage #(
      .W($bits(msl_pkg::msl_in_s))
   ) u_in_stage (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(in_cfg),
      .clk_rise(clk_rise),
      .ce(stage_ce),
      .rst(stage_rst),
      .d(in_d),
      .q(in_q)
   );

   always_comb begin
      pipe_d.load = in_q.load;
      pipe_d.op = in_q.op;
      pipe_d.load_value = in_q.load_value;
      pipe_d.product = in_q.a * in_q.b;
   end

   msl_stage #(
      .W($bits(msl_pkg::msl_pipe_s))
   ) u_pipe_stage (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(pipe_cfg),
      .clk_rise(clk_rise),
      .ce(stage_ce),
      .rst(stage_rst),
      .d(pipe_d),
      .q(pipe_q)
   );

   // Accumulate with one guard bit so the signed range can be checked.
   always_comb begin
      prod_ext = (msl_pkg::ACC_W + 1)'(pipe_q.product);
      if (pipe_q.load) begin
         base = (msl_pkg::ACC_W + 1)'(signed'(pipe_q.load_value));
      end else begin
         unique case (pipe_q.op)
            msl_pkg::OP_ACC: base = (msl_pkg::ACC_W + 1)'(signed'(acc));
            msl_pkg::OP_SUB: base = (msl_pkg::ACC_W + 1)'(signed'(acc));
            msl_pkg::OP_CASC:
               base = (msl_pkg::ACC_W + 1)'(signed'(cascade_in));
            msl_pkg::OP_PASS: base = '0;
         endcase
      end
      if (pipe_q.op == msl_pkg::OP_SUB) begin
         sum = base - prod_ext;
      end else begin
         sum = base + prod_ext;
      end
      next_acc = sum[msl_pkg::ACC_W-1:0];
      next_over = ~sum[msl_pkg::ACC_W] & sum[msl_pkg::ACC_W-1];
      next_under = sum[msl_pkg::ACC_W] & ~sum[msl_pkg::ACC_W-1];
   end

   // Convergent rounding: exact halves go to the even neighbour.
   always_comb begin
      round_up = next_acc[msl_pkg::RND_W-1] &
                 ((|next_acc[msl_pkg::RND_W-2:0]) |
                  next_acc[msl_pkg::RND_W]);
      round_up = round_up & ctrl[msl_pkg::CTRL_ROUND_BIT];
      next_round = next_acc[msl_pkg::ACC_W-1:msl_pkg::RND_W] +
                   {{(msl_pkg::RND_OUT_W - 1){1'b0}}, round_up};
   end

   msl_flags u_flags (
      .value(next_acc),
      .mask(mask),
      .pattern(pattern),
      .over(next_over),
      .under(next_under),
      .flags(next_flags)
   );

   // The output register is never bypassed and holds the accumulator.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc <= '0;
         rounded_result <= '0;
      end else if (out_clr) begin
         acc <= '0;
         rounded_result <= '0;
      end else if (out_go) begin
         acc <= next_acc;
         rounded_result <= next_round;
      end
   end

   // Flags are registered with the output stage.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= '0;
      end else if (out_clr) begin
         flags <= '0;
      end else if (out_go) begin
         flags <= next_flags;
      end
   end

   assign result = acc;
   assign cascade_out = acc;

   // Write channel: address and data are taken in either order.
   assign s_axi_awready = ~aw_hold;
   assign s_axi_wready = ~w_hold;
   assign do_write = aw_hold & w_hold & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_hold <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_hold <= 1'b0;
      end
   end

   always_comb begin
      unique case (aw_addr)
         msl_pkg::CTRL_OFS: wr_ok = 1'b1;
         msl_pkg::STAGE_OFS: wr_ok = 1'b1;
         msl_pkg::MASK_OFS: wr_ok = 1'b1;
         msl_pkg::PATTERN_OFS: wr_ok = 1'b1;
         msl_pkg::IRQ_MASK_OFS: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= msl_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? msl_pkg::RESP_OKAY : msl_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Configuration writes honour the byte strobes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= msl_pkg::CTRL_RST;
         stage_reg <= msl_pkg::STAGE_RST;
         mask <= msl_pkg::MASK_RST;
         pattern <= msl_pkg::PATTERN_RST;
         irq_mask <= msl_pkg::IRQ_MASK_RST;
      end else if (do_write) begin
         if (aw_addr == msl_pkg::CTRL_OFS) begin
            ctrl <= msl_pkg::apply_strb(ctrl, w_data, w_strb);
         end
         if (aw_addr == msl_pkg::STAGE_OFS) begin
            stage_reg <= msl_pkg::apply_strb(stage_reg, w_data, w_strb);
         end
         if (aw_addr == msl_pkg::MASK_OFS) begin
            mask <= msl_pkg::apply_strb(mask, w_data, w_strb);
         end
         if (aw_addr == msl_pkg::PATTERN_OFS) begin
            pattern <= msl_pkg::apply_strb(pattern, w_data, w_strb);
         end
         if (aw_addr == msl_pkg::IRQ_MASK_OFS) begin
            irq_mask <= msl_pkg::apply_strb(irq_mask, w_data, w_strb);
         end
      end
   end

   // Read channel.
   assign s_axi_arready = ~s_axi_rvalid;
   assign ar_take = s_axi_arvalid & s_axi_arready;

   always_comb begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         msl_pkg::CTRL_OFS: rd_data = ctrl;
         msl_pkg::STAGE_OFS: rd_data = stage_reg;
         msl_pkg::MASK_OFS: rd_data = mask;
         msl_pkg::PATTERN_OFS: rd_data = pattern;
         msl_pkg::STATUS_OFS: rd_data = {24'h00_0000, status};
         msl_pkg::IRQ_MASK_OFS: rd_data = irq_mask;
         msl_pkg::RESULT_OFS: rd_data = acc;
         msl_pkg::FLAGS_OFS: rd_data = {24'h00_0000, flags};
         msl_pkg::ROUNDED_OFS: rd_data = {8'h00, rounded_result};
         default: begin
            rd_data = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= msl_pkg::RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_ok ? msl_pkg::RESP_OKAY : msl_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Sticky event bits: a read clears what it returned, a new event wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= '0;
      end else begin
         status <= (status &
                    ~((ar_take && s_axi_araddr == msl_pkg::STATUS_OFS) ?
                      status : '0)) |
                   (out_fire ? next_flags : '0);
      end
   end

   assign irq = |(status & irq_mask[msl_pkg::FLAG_W-1:0]);
endmodule : msl_slice

// ==== rtl/msl_stage.sv ====
// Optional register stage with selectable clock, enable and reset.
`timescale 1ns/1ns
module msl_stage #(
   parameter int W = 8
) (
   // Clock and bus reset
   input wire logic aclk,
   input wire logic aresetn,
   // Stage selection
   input wire msl_pkg::msl_stage_cfg_s cfg,
   input wire logic [3:0] clk_rise,
   input wire logic [1:0] ce,
   input wire logic [1:0] rst,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] held;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         held <= '0;
      end else if (msl_pkg::stage_clr(cfg, clk_rise, rst)) begin
         held <= '0;
      end else if (msl_pkg::stage_go(cfg, clk_rise, ce)) begin
         held <= d;
      end
   end

   assign q = cfg.en ? held : d;
endmodule : msl_stage
